// file: rtl/msd_pkg.sv
package msd_pkg;
   // Address widths
   localparam int MSD_CODE_AW = 16;
   localparam int MSD_DATA_AW = 8;
   localparam int MSD_XDATA_AW = 16;
   localparam int MSD_DW = 8;
   // Program space split: internal code covers 0000 up to this limit
   localparam logic [15:0] MSD_ROM_LAST = 16'h1fff;
   // Data RAM halves
   localparam logic [7:0] MSD_LOWER_LAST = 8'h7f;
   localparam int MSD_RAM_BYTES = 256;
   // Register banks
   localparam int MSD_BANK_REGS = 8;
   localparam int MSD_BANK_SEL_LSB = 3;
   localparam int MSD_BANK_SEL_W = 2;
   // Bit addressing
   localparam logic [7:0] MSD_BIT_REG_BASE = 8'h80;
   localparam logic [2:0] MSD_BIT_GROUP_MASK = 3'h0;
   // Reset value of the program status word
   localparam logic [7:0] MSD_PSW_RST = 8'h00;

   // Internal data access mode
   typedef enum logic [1:0] {
      MSD_MODE_DIRECT,
      MSD_MODE_INDIRECT,
      MSD_MODE_REG,
      MSD_MODE_BIT
   } msd_mode_t;

   // Target of an internal data access
   typedef enum logic [1:0] {
      MSD_TGT_LOWER,
      MSD_TGT_UPPER,
      MSD_TGT_SPECIAL,
      MSD_TGT_NONE
   } msd_tgt_t;

   // Internal data request from the core
   typedef struct packed {
      logic valid;
      logic wr;
      msd_mode_t mode;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic bit_val;
   } msd_dreq_t;

   // Program fetch request
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } msd_freq_t;

   // External data request through the data pointer
   typedef struct packed {
      logic valid;
      logic wr;
      logic [7:0] wdata;
   } msd_xreq_t;
endpackage

// file: rtl/msd_ram.sv
`timescale 1ns/10ps
// Byte store in flip-flops with one write port and one read port
module msd_ram
   import msd_pkg::*;
#(
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Write side
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read side
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem_q [DEPTH];

   // Storage cleared at reset so reads are defined
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   // Combinational read, registered by the parent
   assign rdata = mem_q[raddr];
endmodule // msd_ram

// file: rtl/msd_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Program fetches and data accesses use separate paths and never cross.
// - Program space is read only, up to 64 Kbytes, no write path.
// - Program store strobe pulses only for external fetches, never internal.
// - External access select low sends every fetch outside.
// - Select high: 0000-1FFF internal, 2000-FFFF external.
// - 256 bytes RAM: lower 128, upper 128, plus special register space.
// - Upper RAM and special registers share addresses but separate storage.
// - Lower 128 bytes reachable directly and indirectly, same storage.
// - Lowest 32 bytes are 4 banks of 8, chosen by two status bits.
// - Above 7F, direct goes to special registers, indirect to upper RAM.
// - Stack push and pop are indirect, landing in upper RAM above 7F.
// - 8-bit internal addresses; 16-bit external data address from data pointer.
// - Unoccupied special addresses ignore writes; reads return arbitrary data.
// - Special addresses ending 000 are bit addressable at bit addresses 80-FF.
module msd_decoder
   import msd_pkg::*;
#(
   parameter logic [15:0] ROM_LAST = MSD_ROM_LAST,
   parameter int LOWER_BYTES = 128
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Strap pin from the board
   input wire logic external_access_select_n,
   // Program fetch from the core
   input wire msd_freq_t fetch_req,
   input wire logic [7:0] int_code_data,
   input wire logic [7:0] ext_code_data,
   // Internal data access from the core
   input wire msd_dreq_t data_req,
   input wire logic stack_op,
   // Special register space answers
   input wire logic [7:0] spec_rdata,
   input wire logic spec_occupied,
   // External data through the data pointer
   input wire msd_xreq_t xdata_req,
   input wire logic [15:0] data_pointer_pair,
   input wire logic [7:0] ext_data_rdata,
   // Program fetch results
   output logic program_store_strobe_n,
   output logic [15:0] ext_code_addr,
   output logic [15:0] int_code_addr,
   output logic int_code_rd,
   output logic [7:0] fetch_data,
   output logic fetch_done,
   // Internal data results
   output logic [7:0] data_rdata,
   output logic data_done,
   output logic [1:0] data_target,
   // Special register port
   output logic spec_we,
   output logic [7:0] spec_addr,
   output logic [7:0] spec_wdata,
   // External data port
   output logic [15:0] ext_data_addr,
   output logic ext_data_rd,
   output logic ext_data_wr,
   output logic [7:0] ext_data_wdata,
   output logic [7:0] xdata_rdata,
   output logic xdata_done,
   // Current program status word
   output logic [7:0] program_status_word
);
   localparam logic [7:0] PSW_ADDR = 8'hd0;
   localparam int LAW = $clog2(LOWER_BYTES);

   // Bank-relative register address
   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] n);
      return {3'h0, bank, n};
   endfunction

   // Bit address to byte address; the bit index is taken from its low three bits
   function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
      if (baddr >= MSD_BIT_REG_BASE) begin
         return {baddr[7:3], MSD_BIT_GROUP_MASK};
      end
      return 8'h20 + {4'h0, baddr[6:3]};
   endfunction

   // Strap synchroniser, three stages
   logic ea_s1_q, ea_s2_q, ea_s3_q, ea_n_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ea_s1_q <= 1'b0;
         ea_s2_q <= 1'b0;
         ea_s3_q <= 1'b0;
      end else begin
         ea_s1_q <= external_access_select_n;
         ea_s2_q <= ea_s1_q;
         ea_s3_q <= ea_s2_q;
      end
   end

   // Accept a change once the later stages agree; starts low (all external) for safety
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ea_n_q <= 1'b0;
      end else if (ea_s2_q == ea_s3_q) begin
         ea_n_q <= ea_s3_q;
      end
   end

   // Fetch routing; a read only path, there is no code write port at all
   wire fetch_ext = !ea_n_q || (fetch_req.addr > ROM_LAST);
   wire fetch_int = fetch_req.valid && !fetch_ext;

   logic strobe_n_q, int_rd_q, fetch_done_q, fetch_ext_q;
   logic [15:0] code_addr_q;
   logic [7:0] fetch_data_q;
   // Issue cycle drives address and strobe, next cycle captures data
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         strobe_n_q <= 1'b1;
         int_rd_q <= 1'b0;
         code_addr_q <= 16'h0000;
         fetch_ext_q <= 1'b0;
      end else begin
         strobe_n_q <= !(fetch_req.valid && fetch_ext);
         int_rd_q <= fetch_int;
         fetch_ext_q <= fetch_ext;
         if (fetch_req.valid) begin
            code_addr_q <= fetch_req.addr;
         end
      end
   end

   // Capture follows the route chosen at issue, not whatever request stands now
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         fetch_done_q <= 1'b0;
         fetch_data_q <= 8'h00;
      end else begin
         fetch_done_q <= !strobe_n_q || int_rd_q;
         if (!strobe_n_q || int_rd_q) begin
            fetch_data_q <= fetch_ext_q ? ext_code_data : int_code_data;
         end
      end
   end

   // Fetch outputs come straight from the registers above
   assign program_store_strobe_n = strobe_n_q;
   assign int_code_rd = int_rd_q;
   assign ext_code_addr = code_addr_q;
   assign int_code_addr = code_addr_q;
   assign fetch_done = fetch_done_q;
   assign fetch_data = fetch_data_q;

   // Program status word holds the bank select; it lives in special space here
   logic [7:0] psw_q;
   wire [1:0] bank_sel = psw_q[MSD_BANK_SEL_LSB +: MSD_BANK_SEL_W];

   // Stack operations are forced to indirect mode
   wire msd_mode_t eff_mode =
      msd_mode_t'(stack_op ? MSD_MODE_INDIRECT : data_req.mode);

   // Effective byte address for each mode
   wire [7:0] reg_addr = bank_addr(bank_sel, data_req.addr[2:0]);
   wire [7:0] bit_addr = bit_byte(data_req.addr);
   wire [2:0] bit_idx = data_req.addr[2:0];
   wire [7:0] eff_addr = (eff_mode == MSD_MODE_REG) ? reg_addr :
                         (eff_mode == MSD_MODE_BIT) ? bit_addr : data_req.addr;

   // Target selection; lower half ignores mode so both paths meet one store
   msd_tgt_t tgt;
   always_comb begin
      if (eff_addr <= MSD_LOWER_LAST) begin
         tgt = MSD_TGT_LOWER;
      end else if (eff_mode == MSD_MODE_INDIRECT) begin
         tgt = MSD_TGT_UPPER;
      end else begin
         tgt = MSD_TGT_SPECIAL;
      end
   end

   // The status word sits inside the block, so its writes never reach the special port
   wire psw_hit = (tgt == MSD_TGT_SPECIAL) && (eff_addr == PSW_ADDR);
   wire spec_live = spec_occupied || psw_hit;

   // Read before write for bit updates, current byte from the selected store
   logic [7:0] lower_rd, upper_rd;
   wire [7:0] cur_byte = (tgt == MSD_TGT_LOWER) ? lower_rd :
                         (tgt == MSD_TGT_UPPER) ? upper_rd :
                         psw_hit ? psw_q : spec_rdata;
   // Bit writes merge one bit into the current byte; stores only ever see whole bytes
   wire [7:0] bit_mask = 8'h01 << bit_idx;
   wire [7:0] wr_byte = (eff_mode == MSD_MODE_BIT) ?
                        ((cur_byte & ~bit_mask) | ({8{data_req.bit_val}} & bit_mask)) : data_req.wdata;

   // Write enables; each store sees only the requests routed to it
   wire do_wr = data_req.valid && data_req.wr;
   wire lower_we = do_wr && (tgt == MSD_TGT_LOWER);
   wire upper_we = do_wr && (tgt == MSD_TGT_UPPER);
   wire spec_w = do_wr && (tgt == MSD_TGT_SPECIAL) && spec_occupied && !psw_hit;

   // Lower and upper halves are separate stores, 256 bytes in all
   msd_ram #(.DEPTH(LOWER_BYTES), .AW(LAW)) u_lower (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .we(lower_we),
      .waddr(eff_addr[LAW-1:0]),
      .wdata(wr_byte),
      .raddr(eff_addr[LAW-1:0]),
      .rdata(lower_rd)
   );
   msd_ram #(.DEPTH(MSD_RAM_BYTES - LOWER_BYTES), .AW(LAW)) u_upper (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .we(upper_we),
      .waddr(eff_addr[LAW-1:0]),
      .wdata(wr_byte),
      .raddr(eff_addr[LAW-1:0]),
      .rdata(upper_rd)
   );

   // Status word write; unoccupied special addresses drop writes
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         psw_q <= MSD_PSW_RST;
      end else if (do_wr && psw_hit) begin
         psw_q <= wr_byte;
      end
   end

   // Registered results and special port
   logic [7:0] rdata_q, spec_addr_q, spec_wdata_q;
   logic done_q, spec_we_q;
   logic [1:0] tgt_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         done_q <= 1'b0;
         tgt_q <= 2'(MSD_TGT_NONE);
         spec_we_q <= 1'b0;
         spec_addr_q <= 8'h00;
         spec_wdata_q <= 8'h00;
      end else begin
         done_q <= data_req.valid;
         spec_we_q <= spec_w;
         if (data_req.valid) begin
            tgt_q <= (tgt == MSD_TGT_SPECIAL && !spec_live) ? 2'(MSD_TGT_NONE) : 2'(tgt);
            spec_addr_q <= eff_addr;
            spec_wdata_q <= wr_byte;
            // Bit reads return the bit in the low position
            rdata_q <= (eff_mode == MSD_MODE_BIT) ? {7'h00, cur_byte[bit_idx]} : cur_byte;
         end
      end
   end

   // Internal data outputs, all registered
   assign data_rdata = rdata_q;
   assign data_done = done_q;
   assign data_target = tgt_q;
   assign spec_we = spec_we_q;
   assign spec_addr = spec_addr_q;
   assign spec_wdata = spec_wdata_q;
   assign program_status_word = psw_q;

   // External data: address always the full data pointer
   logic [15:0] xaddr_q;
   logic xrd_q, xwr_q, xdone_q;
   logic [7:0] xwdata_q, xrdata_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         xaddr_q <= 16'h0000;
         xrd_q <= 1'b0;
         xwr_q <= 1'b0;
         xwdata_q <= 8'h00;
      end else begin
         xrd_q <= xdata_req.valid && !xdata_req.wr;
         xwr_q <= xdata_req.valid && xdata_req.wr;
         if (xdata_req.valid) begin
            xaddr_q <= data_pointer_pair;
            xwdata_q <= xdata_req.wdata;
         end
      end
   end

   // Read data captured one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         xdone_q <= 1'b0;
         xrdata_q <= 8'h00;
      end else begin
         xdone_q <= xrd_q || xwr_q;
         if (xrd_q) begin
            xrdata_q <= ext_data_rdata;
         end
      end
   end

   assign ext_data_addr = xaddr_q;
   assign ext_data_rd = xrd_q;
   assign ext_data_wr = xwr_q;
   assign ext_data_wdata = xwdata_q;
   assign xdata_rdata = xrdata_q;
   assign xdata_done = xdone_q;
endmodule // msd_decoder

// file: bench/msd_decoder_asserts.sv
`timescale 1ns/10ps
// Port-level checks of fetch routing and data decode
module msd_decoder_asserts
   import msd_pkg::*;
#(
   parameter logic [15:0] ROM_LAST = MSD_ROM_LAST
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Requests
   input wire logic external_access_select_n,
   input wire msd_freq_t fetch_req,
   input wire msd_dreq_t data_req,
   input wire logic stack_op,
   input wire logic spec_occupied,
   input wire msd_xreq_t xdata_req,
   input wire logic [15:0] data_pointer_pair,
   // Results
   input wire logic program_store_strobe_n,
   input wire logic int_code_rd,
   input wire logic [15:0] int_code_addr,
   input wire logic fetch_done,
   input wire logic data_done,
   input wire logic [1:0] data_target,
   input wire logic spec_we,
   input wire logic [15:0] ext_data_addr,
   input wire logic ext_data_rd,
   input wire logic ext_data_wr,
   input wire logic xdata_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Upper-address access, direct mode with no stack override
   logic hi, dir;
   assign hi = data_req.valid && data_req.addr > MSD_LOWER_LAST;
   assign dir = data_req.mode == MSD_MODE_DIRECT && !stack_op;

   property p_int_quiet; int_code_rd |-> program_store_strobe_n; endproperty
   a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal fetch");
   property p_hi_ext; fetch_req.valid && fetch_req.addr > ROM_LAST |=> !program_store_strobe_n; endproperty
   a_hi_ext: assert property (p_hi_ext) else $error("high fetch not external");
   property p_int_range; int_code_rd |-> int_code_addr <= ROM_LAST; endproperty
   a_int_range: assert property (p_int_range) else $error("internal fetch out of range");
   property p_strap; !external_access_select_n [*5] ##0 fetch_req.valid |=> !program_store_strobe_n; endproperty
   a_strap: assert property (p_strap) else $error("fetch not external with strap low");
   property p_ind_up; hi && (stack_op || data_req.mode == MSD_MODE_INDIRECT) |=> data_done &&
      data_target == MSD_TGT_UPPER; endproperty
   a_ind_up: assert property (p_ind_up) else $error("indirect high not upper RAM");
   property p_dir_spec; hi && dir && spec_occupied && data_req.addr != 8'hd0 |=> data_target == MSD_TGT_SPECIAL;
   endproperty
   a_dir_spec: assert property (p_dir_spec) else $error("direct high not special");
   property p_unocc; hi && dir && !spec_occupied && data_req.wr |=> !spec_we; endproperty
   a_unocc: assert property (p_unocc) else $error("unoccupied write forwarded");
   property p_spec_src; spec_we |-> $past(data_req.valid && data_req.wr && data_req.mode != MSD_MODE_INDIRECT);
   endproperty
   a_spec_src: assert property (p_spec_src) else $error("special write without cause");
   property p_xaddr; xdata_req.valid |=> ext_data_addr == $past(data_pointer_pair) && ext_data_rd != ext_data_wr;
   endproperty
   a_xaddr: assert property (p_xaddr) else $error("external data address wrong");
   property p_xdone; ext_data_rd || ext_data_wr |=> xdata_done; endproperty
   a_xdone: assert property (p_xdone) else $error("external data not done");
endmodule // msd_decoder_asserts

bind msd_decoder msd_decoder_asserts #(.ROM_LAST(ROM_LAST)) u_chk (.sys_clk, .rst_n, .external_access_select_n,
   .fetch_req, .data_req, .stack_op, .spec_occupied, .xdata_req, .data_pointer_pair, .program_store_strobe_n,
   .int_code_rd, .int_code_addr, .fetch_done, .data_done, .data_target, .spec_we, .ext_data_addr, .ext_data_rd,
   .ext_data_wr, .xdata_done);

// file: bench/msd_ext_mem.sv
`timescale 1ns/10ps
// External code and data memories on the far side
module msd_ext_mem (
   // Clock
   input wire logic sys_clk,
   // Code memory
   input wire logic program_store_strobe_n,
   input wire logic [15:0] ext_code_addr,
   output logic [7:0] ext_code_data,
   // Data memory
   input wire logic [15:0] ext_data_addr,
   input wire logic ext_data_rd,
   input wire logic ext_data_wr,
   input wire logic [7:0] ext_data_wdata,
   output logic [7:0] ext_data_rdata
);
   logic [7:0] xmem [0:65535];
   logic code_q, rd_q;
   logic [7:0] clast_q, dlast_q;
   // Data valid only through its sampling cycle; else the bus toggles so stale values never pass
   assign ext_code_data = (!program_store_strobe_n || code_q) ?
      ext_code_addr[7:0] ^ ext_code_addr[15:8] ^ 8'h5a : ~clast_q;
   assign ext_data_rdata = (ext_data_rd || rd_q) ? xmem[ext_data_addr] : ~dlast_q;
   // Code store has no write port at all
   always @(posedge sys_clk) begin
      code_q <= !program_store_strobe_n;
      rd_q <= ext_data_rd;
      clast_q <= ext_code_data;
      dlast_q <= ext_data_rdata;
      if (ext_data_wr) begin
         xmem[ext_data_addr] <= ext_data_wdata;
      end
   end
endmodule // msd_ext_mem

// file: bench/msd_decoder_bench.sv
`timescale 1ns/10ps
// Directed checks of fetch routing, data decode and external data
module msd_decoder_bench;
   import msd_pkg::*;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic external_access_select_n = 1'h1;
   logic stack_op = 1'h0;
   logic spec_occupied = 1'h0;
   msd_freq_t fetch_req = '0;
   msd_dreq_t data_req = '0;
   msd_xreq_t xdata_req = '0;
   logic [15:0] data_pointer_pair = 16'h0;
   logic [7:0] int_code_data, ext_code_data, spec_rdata, ext_data_rdata, fetch_data, data_rdata, spec_addr;
   logic [7:0] spec_wdata, ext_data_wdata, xdata_rdata, program_status_word;
   logic program_store_strobe_n, int_code_rd, fetch_done, data_done, spec_we, ext_data_rd, ext_data_wr;
   logic xdata_done;
   logic [15:0] ext_code_addr, int_code_addr, ext_data_addr;
   logic [1:0] data_target;
   int err_total = 0;
   int tests_run = 0;
   // Internal code and special reads are address patterns
   assign int_code_data = int_code_addr[7:0] ^ 8'hc3;
   assign spec_rdata = data_req.addr ^ 8'h3c;
   always #50 sys_clk = ~sys_clk;

   msd_decoder DUT (.sys_clk, .rst_n, .external_access_select_n, .fetch_req, .int_code_data, .ext_code_data,
      .data_req, .stack_op, .spec_rdata, .spec_occupied, .xdata_req, .data_pointer_pair, .ext_data_rdata,
      .program_store_strobe_n, .ext_code_addr, .int_code_addr, .int_code_rd, .fetch_data, .fetch_done,
      .data_rdata, .data_done, .data_target, .spec_we, .spec_addr, .spec_wdata, .ext_data_addr, .ext_data_rd,
      .ext_data_wr, .ext_data_wdata, .xdata_rdata, .xdata_done, .program_status_word);
   msd_ext_mem MEM (.sys_clk, .program_store_strobe_n, .ext_code_addr, .ext_code_data, .ext_data_addr,
      .ext_data_rd, .ext_data_wr, .ext_data_wdata, .ext_data_rdata);

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic fetch(input logic [15:0] a, input logic ext);
      fetch_req = '{1'h1, a};
      cyc(1);
      fetch_req.valid = 1'h0;
      chk(program_store_strobe_n, !ext);
      chk(int_code_rd, !ext);
      chk(ext ? ext_code_addr : int_code_addr, a);
      cyc(1);
      chk(fetch_done, 1'h1);
      chk(fetch_data, ext ? a[7:0] ^ a[15:8] ^ 8'h5a : a[7:0] ^ 8'hc3);
   endtask
   // Reads pass the expected byte in d, except special reads, which expect the address pattern
   task automatic dacc(input logic w, input msd_mode_t m, input logic [7:0] a, input logic [7:0] d,
      input logic stk, input logic occ, input msd_tgt_t t);
      data_req = '{1'h1, w, m, a, d, d[0]};
      stack_op = stk;
      spec_occupied = occ;
      cyc(1);
      data_req.valid = 1'h0;
      chk(data_done, 1'h1);
      chk(data_target, t);
      chk(spec_we, w && t == MSD_TGT_SPECIAL);
      if (w && t == MSD_TGT_SPECIAL) begin
         chk(spec_addr, a);
         chk(spec_wdata, d);
      end
      if (!w) chk(data_rdata, t == MSD_TGT_SPECIAL ? a ^ 8'h3c : d);
      // Let an edge pass so the next request never rises in the step valid fell
      cyc(1);
   endtask
   task automatic xacc(input logic w, input logic [15:0] a, input logic [7:0] d);
      xdata_req = '{1'h1, w, d};
      data_pointer_pair = a;
      cyc(1);
      xdata_req.valid = 1'h0;
      chk(ext_data_addr, a);
      chk({ext_data_rd, ext_data_wr}, {!w, w});
      if (w) chk(ext_data_wdata, d);
      cyc(1);
      chk(xdata_done, 1'h1);
      if (!w) chk(xdata_rdata, d);
   endtask
   task automatic sc_fetch;
      fetch(16'h0000, 1'h0);
      fetch(16'h1fff, 1'h0);
      fetch(16'h2000, 1'h1);
      fetch(16'hffff, 1'h1);
      external_access_select_n = 1'h0;
      cyc(5);
      fetch(16'h0000, 1'h1);
      fetch(16'h1fff, 1'h1);
   endtask
   task automatic sc_ram;
      dacc(1'h1, MSD_MODE_DIRECT, 8'h10, 8'h21, 1'h0, 1'h0, MSD_TGT_LOWER);
      dacc(1'h0, MSD_MODE_INDIRECT, 8'h10, 8'h21, 1'h0, 1'h0, MSD_TGT_LOWER);
      dacc(1'h1, MSD_MODE_INDIRECT, 8'ha0, 8'h5e, 1'h0, 1'h1, MSD_TGT_UPPER);
      dacc(1'h1, MSD_MODE_DIRECT, 8'ha0, 8'h99, 1'h0, 1'h1, MSD_TGT_SPECIAL);
      dacc(1'h0, MSD_MODE_INDIRECT, 8'ha0, 8'h5e, 1'h0, 1'h1, MSD_TGT_UPPER);
      dacc(1'h0, MSD_MODE_DIRECT, 8'ha0, 8'h00, 1'h0, 1'h1, MSD_TGT_SPECIAL);
      dacc(1'h1, MSD_MODE_DIRECT, 8'hff, 8'h42, 1'h1, 1'h1, MSD_TGT_UPPER);
      dacc(1'h0, MSD_MODE_INDIRECT, 8'hff, 8'h42, 1'h0, 1'h1, MSD_TGT_UPPER);
      dacc(1'h1, MSD_MODE_DIRECT, 8'hf9, 8'h11, 1'h0, 1'h0, MSD_TGT_NONE);
   endtask
   task automatic sc_banks;
      spec_occupied = 1'h1;
      data_req = '{1'h1, 1'h1, MSD_MODE_DIRECT, 8'hd0, 8'h10, 1'h0};
      cyc(1);
      data_req.valid = 1'h0;
      chk(program_status_word, 8'h10);
      cyc(1);
      dacc(1'h1, MSD_MODE_REG, 8'h03, 8'h77, 1'h0, 1'h0, MSD_TGT_LOWER);
      dacc(1'h0, MSD_MODE_DIRECT, 8'h13, 8'h77, 1'h0, 1'h0, MSD_TGT_LOWER);
      // Bit address d3 is bit 3 of the status word
      data_req = '{1'h1, 1'h1, MSD_MODE_BIT, 8'hd3, 8'h00, 1'h1};
      cyc(1);
      data_req.valid = 1'h0;
      chk(program_status_word, 8'h18);
      cyc(1);
      // Low bit addresses land in lower RAM; bit 0a is bit 2 of byte 21
      dacc(1'h1, MSD_MODE_BIT, 8'h0a, 8'h01, 1'h0, 1'h0, MSD_TGT_LOWER);
      dacc(1'h0, MSD_MODE_DIRECT, 8'h21, 8'h04, 1'h0, 1'h0, MSD_TGT_LOWER);
      dacc(1'h0, MSD_MODE_BIT, 8'h0a, 8'h01, 1'h0, 1'h0, MSD_TGT_LOWER);
   endtask
   task automatic sc_xdata;
      xacc(1'h1, 16'hbeef, 8'ha5);
      xacc(1'h1, 16'h00ef, 8'h3c);
      xacc(1'h0, 16'hbeef, 8'ha5);
   endtask
   task automatic results;
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Reset for two cycles, let the strap settle, then run the scenarios
   initial begin
      cyc(2);
      rst_n = 1'h1;
      cyc(5);
      sc_fetch();
      sc_ram();
      sc_banks();
      sc_xdata();
      results();
   end
endmodule // msd_decoder_bench
